// ### src/pmdc_pkg.sv
// shared constants and carrier types of the page-mode dram controller
package pmdc_pkg;
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned PAGE_BYTES        = 512;
  localparam int unsigned PAGE_BITS         = $clog2(PAGE_BYTES);
  localparam int unsigned ADDR_W            = 24;
  localparam int unsigned TAG_W             = ADDR_W - PAGE_BITS;
  localparam int unsigned ROW_LIMIT_NS      = 10_000;
  localparam int unsigned CHRDY_DRIVE_NS    = 15;
  localparam int unsigned CHRDY_DRIVE_CYC   =
    (CHRDY_DRIVE_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
    (CHRDY_DRIVE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PRECHARGE_CYC     = 2;
  localparam logic [11:0] REG_CTRL          = 12'h000;
  localparam logic [11:0] REG_STATUS        = 12'h004;
  localparam logic [11:0] REG_HITS          = 12'h008;
  localparam int unsigned CTRL_FORCE_NP     = 0;
  localparam int unsigned ST_PAGE_VALID     = 0;
  localparam int unsigned ST_ROW_ACTIVE     = 1;
  localparam int unsigned ST_TIMEOUT        = 2;
  localparam int unsigned ST_PAGE_MODE      = 3;
  localparam int unsigned ST_HITS_LSB       = 16;
  localparam logic        CTRL_FORCE_NP_RST = 1'b0;

  typedef enum logic [1:0] {
    PMDC_IDLE,
    PMDC_PRE,
    PMDC_ROW,
    PMDC_DATA
  } pmdc_state_e;

  // dram-facing pin group
  typedef struct packed {
    logic [3:0] row_strobe_n;
    logic       colstrobe_b1_hi_n;
    logic       colstrobe_b1_lo_n;
    logic       colstrobe_b0_hi_n;
    logic       colstrobe_b0_lo_n;
    logic       row_col_mux_sel;
    logic       early_write_a_n;
    logic       early_write_b_n;
  } pmdc_dram_s;
endpackage : pmdc_pkg

// ### src/pmdc_ctrl.sv
// page-mode dram controller: page tracking, strobes, wait states, apb regs
//
// Contract
// - a page is 512 bytes; only the low nine address bits vary inside
// - page mode only when select low and hold acknowledge low
// - page-mode reads in the previous page complete with zero wait states
// - row strobes stay asserted between cycles on page hits
// - page miss or write takes two waits with row strobes precharged
// - four row strobe outputs carry one identical signal
// - lane enables from cpu or external byte inputs per hold acknowledge
// - pair enables from incoming strobes and bank select, ANDed with lanes
// - count row active time on the fixed timebase; force precharge at 10 us
// - limit during same-page reads inserts a false page miss
// - zero-wait output pulled low for every page hit
// - channel ready pulled low for every two-wait-state cycle
// - channel ready driven high briefly on release, then floated
// - mux select follows row strobes one half period later normally
// - zero-wait non-page cycles switch mux select with row strobes
// - mux select held low during refresh cycles
// - both early writes low in second phase, high when ready sampled low
// - under hold acknowledge memory strobes give access type
// - memory read and write strobes sampled before use by the fsm
// - channel ready never driven low in non-cpu mode; master extends
// - non-cpu mode with a wait strap low makes column strobes early
// - with page select high the wait straps choose zero or one wait
// - test input low floats every output (the apb outputs prdata, pready and pslverr stay driven)
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module pmdc_ctrl #(
  parameter int unsigned TB_PERIOD_NS = 70,
  parameter int unsigned ROW_LIMIT_TICKS =
    pmdc_pkg::ROW_LIMIT_NS / TB_PERIOD_NS
) (
  input  wire logic                        clock,
  input  wire logic                        srst,
  // processor / bus master side
  input  wire logic                        cpu_mem_start,
  input  wire logic                        cpu_write,
  input  wire logic [pmdc_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic                        byte_high_en_n,
  input  wire logic                        ext_addr_bit0,
  input  wire logic                        ext_byte_high_en_n,
  input  wire logic                        hold_acknowledge,
  input  wire logic                        mem_read_n,
  input  wire logic                        mem_write_n,
  input  wire logic                        bus_ready_n,
  input  wire logic                        refresh_n,
  // companion controller strobes
  input  wire logic                        in_colstrobe0,
  input  wire logic                        in_colstrobe1,
  input  wire logic                        in_rowstrobe0,
  input  wire logic                        in_rowstrobe1,
  // straps and misc
  input  wire logic                        page_mode_n,
  input  wire logic                        read_wait_strap,
  input  wire logic                        write_wait_strap,
  input  wire logic                        bank_pair_select,
  input  wire logic                        fixed_timebase_clk,
  input  wire logic                        test_n,
  // dram pins and wait-state pins
  output pmdc_pkg::pmdc_dram_s             dram,
  output logic                             dram_oe,
  output logic                             zero_wait_n_o,
  output logic                             zero_wait_n_oe,
  output logic                             chan_ready_o,
  output logic                             chan_ready_oe,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr
);

  typedef struct packed {
    pmdc_pkg::pmdc_state_e       st;
    logic [pmdc_pkg::TAG_W-1:0]  tag;
    logic                        page_valid;
    logic                        row_act;
    logic                        mux_sel;
    logic                        ew_n;
    logic                        zw_oe;
    logic                        cr_o;
    logic                        cr_oe;
    logic [1:0]                  cr_cnt;
    logic [1:0]                  pre_cnt;
    logic                        tb_q;
    logic [15:0]                 tb_cnt;
    logic                        timeout;
    logic                        mrd_q;
    logic                        mrd_q2;
    logic                        mwr_q;
    logic                        mwr_q2;
    logic                        cyc_ext;
    logic                        pre_only;
    logic [3:0]                  col_q;
    logic                        force_np;
    logic [15:0]                 hit_cnt;
    logic [31:0]                 rdata;
  } pmdc_regs_s;

  localparam logic [15:0] LIMIT      = 16'(ROW_LIMIT_TICKS);
  localparam logic [1:0]  PRE_LOAD   = 2'(pmdc_pkg::PRECHARGE_CYC - 1);
  localparam logic [1:0]  CR_LOAD    = 2'(pmdc_pkg::CHRDY_DRIVE_CYC);

  pmdc_regs_s r;
  pmdc_regs_s next_r;

  // column enables {b1 hi, b1 lo, b0 hi, b0 lo}, active high
  function automatic logic [3:0] col_decode(
    input logic cs0,
    input logic cs1,
    input logic rs0,
    input logic rs1,
    input logic bsel,
    input logic hi_n,
    input logic lo_bit
  );
    logic pair1_enable;
    logic pair0_enable;
    logic hi_en;
    logic lo_en;
    pair1_enable = (bsel & cs1 & rs1) | (!bsel & cs1 & rs0);
    pair0_enable = (bsel & cs0 & rs0) | (!bsel & cs0 & rs1);
    hi_en = !hi_n;
    lo_en = !lo_bit;
    return {pair1_enable & hi_en, pair1_enable & lo_en,
            pair0_enable & hi_en, pair0_enable & lo_en};
  endfunction

  logic       page_mode;
  logic       hit;
  logic       is_write;
  logic       start_cpu;
  logic       start_ext;
  logic       start;
  logic       cyc_end;
  logic       zero_ws;
  logic       fast_col;
  logic       tb_rise;
  logic       lane_hi_n;
  logic       lane_lo;
  logic [3:0] col_now;
  logic       apb_setup;
  logic       apb_acc;
  logic       addr_ok;

  always_comb begin
    page_mode = !page_mode_n && !hold_acknowledge && !r.force_np;
    lane_hi_n = hold_acknowledge ? ext_byte_high_en_n : byte_high_en_n;
    lane_lo   = hold_acknowledge ? ext_addr_bit0 : cpu_addr[0];
    col_now   = col_decode(in_colstrobe0, in_colstrobe1, in_rowstrobe0,
                           in_rowstrobe1, bank_pair_select, lane_hi_n,
                           lane_lo);
    start_cpu = !hold_acknowledge && cpu_mem_start;
    start_ext = hold_acknowledge &&
                ((!r.mrd_q && r.mrd_q2) || (!r.mwr_q && r.mwr_q2));
    start     = (r.st == pmdc_pkg::PMDC_IDLE) && (start_cpu || start_ext);
    is_write  = hold_acknowledge ? !r.mwr_q : cpu_write;
    hit = page_mode && r.page_valid && r.row_act && !is_write &&
          !r.timeout &&
          (cpu_addr[pmdc_pkg::ADDR_W-1:pmdc_pkg::PAGE_BITS] == r.tag);
    // straps pick zero or one wait outside page mode
    if (hold_acknowledge) begin
      zero_ws = !read_wait_strap || !write_wait_strap;
    end else begin
      zero_ws = is_write ? !write_wait_strap : !read_wait_strap;
    end
    fast_col = hold_acknowledge &&
               (!read_wait_strap || !write_wait_strap);
    cyc_end  = r.cyc_ext ? (r.mrd_q && r.mwr_q) : !bus_ready_n;
    tb_rise  = fixed_timebase_clk && !r.tb_q;
    apb_setup = psel && !penable;
    apb_acc   = psel && penable;
    addr_ok   = (paddr == pmdc_pkg::REG_CTRL) ||
                (paddr == pmdc_pkg::REG_STATUS) ||
                (paddr == pmdc_pkg::REG_HITS);
  end

  always_comb begin
    next_r        = r;
    next_r.mrd_q  = mem_read_n;
    next_r.mrd_q2 = r.mrd_q;
    next_r.mwr_q  = mem_write_n;
    next_r.mwr_q2 = r.mwr_q;
    next_r.tb_q   = fixed_timebase_clk;
    next_r.col_q  = col_now;

    // row active timer on the fixed timebase
    if (!r.row_act) begin
      next_r.tb_cnt  = '0;
      next_r.timeout = 1'b0;
    end else if (tb_rise && !r.timeout) begin
      next_r.tb_cnt = r.tb_cnt + 16'h0001;
      if (r.tb_cnt + 16'h0001 >= LIMIT) begin
        next_r.timeout = 1'b1;
      end
    end

    // channel ready: drive high briefly after release, then float
    if (r.cr_oe && r.cr_o) begin
      if (r.cr_cnt <= 2'h1) begin
        next_r.cr_oe = 1'b0;
      end else begin
        next_r.cr_cnt = r.cr_cnt - 2'h1;
      end
    end

    case (r.st)
      pmdc_pkg::PMDC_IDLE: begin
        if (start) begin
          next_r.tag     = cpu_addr[pmdc_pkg::ADDR_W-1:pmdc_pkg::PAGE_BITS];
          next_r.cyc_ext = hold_acknowledge;
          next_r.pre_only = 1'b0;
          next_r.ew_n    = !is_write;
          if (hit) begin
            next_r.zw_oe   = 1'b1;
            next_r.hit_cnt = r.hit_cnt + 16'h0001;
            next_r.st      = pmdc_pkg::PMDC_DATA;
          end else if (page_mode) begin
            next_r.row_act = 1'b0;
            next_r.mux_sel = 1'b0;
            next_r.pre_cnt = PRE_LOAD;
            next_r.cr_o    = 1'b0;
            next_r.cr_oe   = 1'b1;
            next_r.st      = pmdc_pkg::PMDC_PRE;
          end else if (r.row_act) begin
            next_r.row_act = 1'b0;
            next_r.mux_sel = 1'b0;
            next_r.pre_cnt = PRE_LOAD;
            next_r.st      = pmdc_pkg::PMDC_PRE;
          end else begin
            next_r.row_act = 1'b1;
            if (zero_ws) begin
              next_r.mux_sel = 1'b1;
              next_r.st      = pmdc_pkg::PMDC_DATA;
            end else begin
              next_r.st = pmdc_pkg::PMDC_ROW;
            end
          end
        end else if (r.row_act && r.timeout) begin
          next_r.row_act    = 1'b0;
          next_r.mux_sel    = 1'b0;
          next_r.page_valid = 1'b0;
          next_r.pre_only   = 1'b1;
          next_r.pre_cnt    = PRE_LOAD;
          next_r.st         = pmdc_pkg::PMDC_PRE;
        end
      end
      pmdc_pkg::PMDC_PRE: begin
        if (r.pre_cnt == 2'h0) begin
          if (r.pre_only) begin
            next_r.st = pmdc_pkg::PMDC_IDLE;
          end else begin
            next_r.row_act = 1'b1;
            next_r.st      = pmdc_pkg::PMDC_ROW;
          end
        end else begin
          next_r.pre_cnt = r.pre_cnt - 2'h1;
        end
      end
      pmdc_pkg::PMDC_ROW: begin
        next_r.mux_sel = 1'b1;
        if (r.cr_oe && !r.cr_o) begin
          next_r.cr_o   = 1'b1;
          next_r.cr_cnt = CR_LOAD;
        end
        next_r.st = pmdc_pkg::PMDC_DATA;
      end
      pmdc_pkg::PMDC_DATA: begin
        if (cyc_end) begin
          next_r.ew_n  = 1'b1;
          next_r.zw_oe = 1'b0;
          if (page_mode && !r.cyc_ext) begin
            next_r.page_valid = 1'b1;
          end else begin
            next_r.row_act    = 1'b0;
            next_r.mux_sel    = 1'b0;
            next_r.page_valid = 1'b0;
          end
          next_r.st = pmdc_pkg::PMDC_IDLE;
        end
      end
      default: next_r.st = pmdc_pkg::PMDC_IDLE;
    endcase

    // apb register file
    if (apb_setup) begin
      case (paddr)
        pmdc_pkg::REG_CTRL:
          next_r.rdata = {31'h0, r.force_np};
        pmdc_pkg::REG_STATUS:
          next_r.rdata = {r.hit_cnt, 12'h000, page_mode, r.timeout,
                          r.row_act, r.page_valid};
        pmdc_pkg::REG_HITS:
          next_r.rdata = {16'h0000, r.hit_cnt};
        default:
          next_r.rdata = 32'h0000_0000;
      endcase
    end
    if (apb_acc && pwrite && paddr == pmdc_pkg::REG_CTRL) begin
      next_r.force_np = pwdata[pmdc_pkg::CTRL_FORCE_NP];
    end
    if (apb_acc && pwrite && paddr == pmdc_pkg::REG_HITS) begin
      next_r.hit_cnt = 16'h0000;
    end

    if (srst) begin
      next_r            = '0;
      next_r.st         = pmdc_pkg::PMDC_IDLE;
      next_r.ew_n       = 1'b1;
      next_r.cr_o       = 1'b1;
      next_r.mrd_q      = 1'b1;
      next_r.mrd_q2     = 1'b1;
      next_r.mwr_q      = 1'b1;
      next_r.mwr_q2     = 1'b1;
      next_r.force_np   = pmdc_pkg::CTRL_FORCE_NP_RST;
    end
  end

  always_ff @(posedge clock) begin
    r <= next_r;
  end

  always_comb begin
    logic [3:0] col_en;
    col_en = fast_col ? col_now : r.col_q;
    dram.row_strobe_n      = {4{!r.row_act}};
    dram.colstrobe_b1_hi_n = !col_en[3];
    dram.colstrobe_b1_lo_n = !col_en[2];
    dram.colstrobe_b0_hi_n = !col_en[1];
    dram.colstrobe_b0_lo_n = !col_en[0];
    dram.row_col_mux_sel   = r.mux_sel && refresh_n;
    dram.early_write_a_n   = r.ew_n;
    dram.early_write_b_n   = r.ew_n;
    dram_oe        = test_n;
    zero_wait_n_o  = 1'b0;
    zero_wait_n_oe = r.zw_oe && test_n;
    chan_ready_o   = r.cr_o;
    chan_ready_oe  = r.cr_oe && test_n;
    prdata  = r.rdata;
    pready  = 1'b1;
    pslverr = apb_acc && !addr_ok;
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  chk_hit_zero_wait: assert property (
    start && hit |=> r.st == pmdc_pkg::PMDC_DATA && r.zw_oe && r.row_act)
    else $error("page hit did not give a zero-wait cycle");
  chk_miss_precharge: assert property (
    start && page_mode && !hit |=> !r.row_act [*2] ##1 r.row_act)
    else $error("page miss precharge length wrong");
  chk_hit_holds_row: assert property (
    r.st == pmdc_pkg::PMDC_DATA && r.zw_oe |-> r.row_act
      && dram.row_strobe_n == 4'h0)
    else $error("row strobes dropped during page hit");
  chk_no_chrdy_ext: assert property (
    r.cr_oe && !r.cr_o |-> !r.cyc_ext && !hold_acknowledge)
    else $error("channel ready pulled low in non-cpu mode");
  chk_chrdy_release: assert property (
    (r.cr_oe && !r.cr_o) ##1 (r.cr_oe && r.cr_o) |=> !r.cr_oe)
    else $error("channel ready not floated after high drive");
  chk_mux_half_late: assert property (
    r.st == pmdc_pkg::PMDC_PRE ##1 r.st == pmdc_pkg::PMDC_ROW
      |-> !r.mux_sel && r.row_act ##1 r.mux_sel)
    else $error("mux select not one step after row strobes");
  chk_mux_same_edge: assert property (
    start && !page_mode && !r.row_act && zero_ws
      |=> r.row_act && r.mux_sel)
    else $error("zero-wait mux select not with row strobes");
  chk_early_write: assert property (
    start && is_write |=> !dram.early_write_a_n && !dram.early_write_b_n
      ##[0:1000] (r.st == pmdc_pkg::PMDC_IDLE && r.ew_n))
    else $error("early write not asserted and released");
  chk_timeout_miss: assert property (
    start && r.timeout && page_mode |=> r.st == pmdc_pkg::PMDC_PRE)
    else $error("timeout did not force a page miss");
  chk_reset_state: assert property (@(posedge clock) disable iff (1'b0)
    srst |=> !r.page_valid && !r.row_act && r.ew_n && !r.cr_oe)
    else $error("reset left strobes or page tracker active");

  cov_page_hit: cover property (start && hit);
  cov_page_miss: cover property (start && page_mode && !hit);
  cov_forced_pre: cover property (r.st == pmdc_pkg::PMDC_IDLE && r.timeout
                                  && r.row_act);
  cov_ext_cycle: cover property (start_ext);

endmodule // pmdc_ctrl

`default_nettype wire

// ### verif/pmdc_bus_partner.sv
// cpu-side bus partner: ends each cpu cycle once the wait-state pins allow
`timescale 1ns/1ps
`default_nettype none

module pmdc_bus_partner (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       cpu_mem_start,
  input  wire logic       hold_acknowledge,
  input  wire logic       zero_wait_n_oe,
  input  wire logic       chan_ready_wire,
  input  wire logic       row_col_mux_sel,
  input  wire logic [1:0] slow,
  output logic            bus_ready_n,
  output logic            done
);
  logic       busy;
  logic [2:0] cnt;

  always_ff @(posedge clock) begin
    done <= 1'b0;
    if (srst) begin
      busy        <= 1'b0;
      cnt         <= 3'h0;
      bus_ready_n <= 1'b1;
    end else if (!busy) begin
      cnt  <= 3'h0;
      busy <= cpu_mem_start && !hold_acknowledge;
    end else if (!bus_ready_n) begin
      // ready is held low for two edges, then released
      cnt <= cnt + 3'h1;
      if (cnt == 3'h1) begin
        bus_ready_n <= 1'b1;
        busy        <= 1'b0;
        done        <= 1'b1;
      end
    end else if (zero_wait_n_oe || (chan_ready_wire && row_col_mux_sel)) begin
      // a slow partner waits up to three more edges before ending
      if (cnt >= {1'b0, slow}) begin
        bus_ready_n <= 1'b0;
        cnt         <= 3'h0;
      end else begin
        cnt <= cnt + 3'h1;
      end
    end
  end
endmodule // pmdc_bus_partner

`default_nettype wire

// ### verif/tb.sv
// self-checking bench of the page-mode dram controller
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clock, srst, cpu_mem_start, cpu_write, byte_high_en_n;
  logic ext_addr_bit0, ext_byte_high_en_n, hold_acknowledge, mem_read_n;
  logic mem_write_n, bus_ready_n, refresh_n, in_colstrobe0, in_colstrobe1;
  logic in_rowstrobe0, in_rowstrobe1, page_mode_n, read_wait_strap;
  logic write_wait_strap, bank_pair_select, fixed_timebase_clk, test_n;
  logic psel, penable, pwrite, pready, pslverr, done, tb_run;
  logic dram_oe, zero_wait_n_o, zero_wait_n_oe, chan_ready_o, chan_ready_oe;
  logic [23:0] cpu_addr, a;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [1:0]  slow;
  logic        err, cr_wire, zw_q, crl_q, cr_oe_q, cr_o_q, row_hi, ew_seen;
  logic        mux_c1, p1, p0;
  logic [3:0]  ce;
  logic [1:0]  exp_q[$];
  pmdc_pkg::pmdc_dram_s dram;
  int mismatches, n_checks, n_hit;

  assign cr_wire = chan_ready_oe ? chan_ready_o : 1'b1;

  pmdc_ctrl #(.ROW_LIMIT_TICKS(4)) uut (
    .clock(clock), .srst(srst), .cpu_mem_start(cpu_mem_start),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr),
    .byte_high_en_n(byte_high_en_n), .ext_addr_bit0(ext_addr_bit0),
    .ext_byte_high_en_n(ext_byte_high_en_n),
    .hold_acknowledge(hold_acknowledge), .mem_read_n(mem_read_n),
    .mem_write_n(mem_write_n), .bus_ready_n(bus_ready_n),
    .refresh_n(refresh_n), .in_colstrobe0(in_colstrobe0),
    .in_colstrobe1(in_colstrobe1), .in_rowstrobe0(in_rowstrobe0),
    .in_rowstrobe1(in_rowstrobe1), .page_mode_n(page_mode_n),
    .read_wait_strap(read_wait_strap), .write_wait_strap(write_wait_strap),
    .bank_pair_select(bank_pair_select),
    .fixed_timebase_clk(fixed_timebase_clk), .test_n(test_n),
    .dram(dram), .dram_oe(dram_oe), .zero_wait_n_o(zero_wait_n_o),
    .zero_wait_n_oe(zero_wait_n_oe), .chan_ready_o(chan_ready_o),
    .chan_ready_oe(chan_ready_oe), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  pmdc_bus_partner partner (
    .clock(clock), .srst(srst), .cpu_mem_start(cpu_mem_start),
    .hold_acknowledge(hold_acknowledge), .zero_wait_n_oe(zero_wait_n_oe),
    .chan_ready_wire(cr_wire), .row_col_mux_sel(dram.row_col_mux_sel),
    .slow(slow), .bus_ready_n(bus_ready_n), .done(done));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // cycle kind seen at the pins: 1 zero-wait hit, 2 two-wait miss
  task automatic check_cyc(input logic [1:0] got);
    logic [1:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 2'h3;
    check_val({30'h0, got}, {30'h0, e});
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  always @(posedge clock) begin
    if (srst) fixed_timebase_clk <= 1'b0;
    else if (tb_run) fixed_timebase_clk <= ~fixed_timebase_clk;
  end

  always @(negedge clock) begin
    if (!srst && test_n) begin
      if (zero_wait_n_oe && !zw_q) check_cyc(2'h1);
      if (chan_ready_oe && !chan_ready_o && !crl_q) check_cyc(2'h2);
      if (zero_wait_n_oe) check_val(dram.row_strobe_n, 32'h0);
      if (crl_q && dram.row_strobe_n == 4'hF) row_hi = 1'b1;
      if (cr_oe_q && !chan_ready_oe) begin
        check_val(cr_o_q, 32'h1);
        check_val(row_hi, 32'h1);
        row_hi = 1'b0;
      end
      if (hold_acknowledge && chan_ready_oe) check_val(chan_ready_o, 1);
      check_val({31'h0, dram.row_strobe_n == 4'h0 ||
                 dram.row_strobe_n == 4'hF}, 32'h1);
      check_val(dram.early_write_a_n, dram.early_write_b_n);
      if (!dram.early_write_a_n) ew_seen = 1'b1;
    end
    zw_q    = zero_wait_n_oe;
    crl_q   = chan_ready_oe && !chan_ready_o;
    cr_oe_q = chan_ready_oe;
    cr_o_q  = chan_ready_o;
  end

  task automatic apb(input logic [11:0] ad, input logic w,
                     input logic [31:0] d);
    int i;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= ad;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      mismatches++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cpu_cycle(input logic [23:0] ad, input logic wr,
                           input logic [1:0] exp);
    int i;
    if (exp != 2'h0) exp_q.push_back(exp);
    ew_seen = 1'b0;
    seed = xs(seed);
    @(posedge clock);
    cpu_mem_start  <= 1'b1;
    cpu_addr       <= ad;
    cpu_write      <= wr;
    byte_high_en_n <= seed[0];
    slow           <= seed[2:1];
    @(posedge clock);
    cpu_mem_start <= 1'b0;
    #1;
    mux_c1 = dram.row_col_mux_sel;
    for (i = 0; i < 64; i++) begin
      @(posedge clock);
      #1;
      if (done === 1'b1) break;
    end
    if (i == 64) begin
      mismatches++;
      summarize();
    end
    check_val(ew_seen, wr);
    repeat (2) @(posedge clock);
  endtask

  initial begin
    {cpu_mem_start, cpu_write, hold_acknowledge, in_colstrobe0} = 4'h0;
    {in_colstrobe1, in_rowstrobe0, in_rowstrobe1, page_mode_n} = 4'h0;
    {bank_pair_select, psel, penable, pwrite} = 4'h0;
    {byte_high_en_n, ext_addr_bit0, ext_byte_high_en_n, mem_read_n} = 4'hF;
    {mem_write_n, refresh_n, read_wait_strap, write_wait_strap} = 4'hF;
    {test_n, srst, tb_run, slow} = 5'h18;
    {zw_q, crl_q, cr_oe_q, cr_o_q, row_hi, ew_seen} = 6'h0;
    cpu_addr = 24'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    seed = 32'd88065;
    mismatches = 0;
    n_checks = 0;
    n_hit = 0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    #1;
    check_val({19'h0, dram.row_strobe_n, dram.colstrobe_b1_hi_n,
      dram.colstrobe_b1_lo_n, dram.colstrobe_b0_hi_n, dram.colstrobe_b0_lo_n,
      dram.row_col_mux_sel, dram.early_write_a_n, dram.early_write_b_n,
      zero_wait_n_oe, chan_ready_oe}, 32'h0000_1FEC);
    apb(pmdc_pkg::REG_STATUS, 1'b0, 32'h0);
    check_val(rd[pmdc_pkg::ST_PAGE_VALID], 32'h0);
    apb(pmdc_pkg::REG_CTRL, 1'b1, 32'h1);
    apb(pmdc_pkg::REG_CTRL, 1'b0, 32'h0);
    check_val(rd, 32'h1);
    apb(pmdc_pkg::REG_CTRL, 1'b1, 32'h0);
    apb(12'hFFC, 1'b0, 32'h0);
    check_val({31'h0, err}, 32'h1);
    check_val(rd, 32'h0);
    seed = xs(seed);
    a = seed[23:0];
    cpu_cycle(a, 1'b0, 2'h2);
    repeat (3) begin
      seed = xs(seed);
      cpu_cycle({a[23:9], seed[8:0]}, 1'b0, 2'h1);
      n_hit++;
    end
    a = a ^ 24'h000200;
    cpu_cycle(a, 1'b0, 2'h2);
    cpu_cycle(a, 1'b1, 2'h2);
    cpu_cycle(a ^ 24'h0001FF, 1'b0, 2'h1);
    n_hit++;
    apb(pmdc_pkg::REG_STATUS, 1'b0, 32'h0);
    check_val({rd[31:16], 15'h0, rd[pmdc_pkg::ST_PAGE_VALID]},
              {n_hit[15:0], 16'h1});
    apb(pmdc_pkg::REG_HITS, 1'b1, 32'h0);
    apb(pmdc_pkg::REG_HITS, 1'b0, 32'h0);
    check_val({31'h0, err}, 32'h0);
    check_val(rd, 32'h0);
    tb_run <= 1'b1;
    repeat (20) @(posedge clock);
    tb_run <= 1'b0;
    cpu_cycle(a, 1'b0, 2'h2);
    page_mode_n <= 1'b1;
    cpu_cycle(a, 1'b0, 2'h0);
    check_val(mux_c1, 32'h0);
    read_wait_strap  <= 1'b0;
    write_wait_strap <= 1'b0;
    cpu_cycle(a, 1'b0, 2'h0);
    check_val(mux_c1, 32'h1);
    hold_acknowledge <= 1'b1;
    repeat (32) begin
      @(posedge clock);
      seed = xs(seed);
      // each step drives random strobes, lanes, refresh and mem_read_n, then checks column strobes
      {in_colstrobe0, in_colstrobe1, in_rowstrobe0, in_rowstrobe1,
       bank_pair_select, ext_addr_bit0, ext_byte_high_en_n,
       byte_high_en_n, refresh_n, mem_read_n} <= seed[9:0];
      #2;
      p1 = in_colstrobe1 && (bank_pair_select ? in_rowstrobe1 : in_rowstrobe0);
      p0 = in_colstrobe0 && (bank_pair_select ? in_rowstrobe0 : in_rowstrobe1);
      ce = ~{p1 && !ext_byte_high_en_n, p1 && !ext_addr_bit0,
             p0 && !ext_byte_high_en_n, p0 && !ext_addr_bit0};
      check_val({28'h0, dram.colstrobe_b1_hi_n, dram.colstrobe_b1_lo_n,
                 dram.colstrobe_b0_hi_n, dram.colstrobe_b0_lo_n},
                {28'h0, ce});
      if (!refresh_n) check_val(dram.row_col_mux_sel, 32'h0);
    end
    @(posedge clock);
    test_n <= 1'b0;
    #2;
    check_val({dram_oe, zero_wait_n_oe, chan_ready_oe}, 32'h0);
    check_val(exp_q.size(), 32'h0);
    summarize();
  end
endmodule // tb

`default_nettype wire
